// File: rtl/smrf_top.sv
// Supply monitor: detector control, threshold flag, reset-source flags
//
// Operation
// - Source select bit is read/write; 0 watches main supply, 1 the detect pin.
// - Auxiliary detection works only while the low-voltage detector option is on.
// - With interrupt enable set, every flag change raises a request; otherwise none.
// - Pending detector request clears by hardware on entry to its service routine.
// - Threshold flag is read-only, hardware-driven: 1 below, 0 above threshold.
// - Low-voltage reset flag sets on that reset, clears by writing zero or by power-on reset.
// - With the detector option off, the low-voltage reset flag is undefined.
// - Watchdog flag sets on watchdog reset, clears by writing zero or by any reset that lacks the watchdog cause or carries the low-voltage one.
// - Flags 00 mean pin reset, 01 watchdog, 1x low-voltage reset.
// - Pin or watchdog reset leaves the low-voltage reset flag untouched.
// - After reset select, enable and reserved bits read zero; flags from hardware.
`timescale 1ns/1ps
`default_nettype none

`include "smrf_map.svh"

module smrf_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              lvd_option_en,
  input  wire logic              avd_cmp_vdd,
  input  wire logic              avd_cmp_evd,
  input  wire logic              rst_src_por,
  input  wire logic              rst_src_lvd,
  input  wire logic              rst_src_wdg,
  input  wire logic              avd_irq_ack,
  output logic                   aux_detect_threshold_flag,
  output logic                   irq
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  smrf_pkg::smrf_state_t st_ff;
  smrf_pkg::smrf_state_t nxt_st;

  logic [1:0] cmp_sync;
  logic       sel_cmp;
  logic       new_flag;
  logic       flag_chg;
  logic       csr_wr;
  logic       ist_wr;
  logic       msk_wr;
  logic [2:0] ist_evt;
  logic [2:0] ist_clr;

  // --------------------------------------------------------------------------
  // Comparator synchronisers
  // --------------------------------------------------------------------------
  // Raw comparators are asynchronous; one clean level per edge avoids
  // double pending on a glitch at the sampling edge
  smrf_sync #(
    .WIDTH (2)
  ) u_cmp_sync (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .async_in ({avd_cmp_evd, avd_cmp_vdd}),
    .sync_out (cmp_sync)
  );

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  // Clears are applied first and sets after, so an event in the clear
  // cycle survives
  always_comb begin
    nxt_st   = st_ff;
    sel_cmp  = st_ff.src_sel ? cmp_sync[1] : cmp_sync[0];
    new_flag = lvd_option_en & sel_cmp;
    flag_chg = new_flag ^ st_ff.avd_flag;
    csr_wr   = reg_wr && (reg_addr == ADDR_W'(`SMRF_ADDR_CSR));
    ist_wr   = reg_wr && (reg_addr == ADDR_W'(`SMRF_ADDR_ISTAT));
    msk_wr   = reg_wr && (reg_addr == ADDR_W'(`SMRF_ADDR_IMASK));
    ist_evt  = 3'h0;
    ist_clr  = 3'h0;

    // Threshold flag follows the selected comparator every cycle
    nxt_st.avd_flag = new_flag;

    // Edge events, only while the enable bit is set
    if (st_ff.irq_en && flag_chg) begin
      ist_evt[`SMRF_IST_TOGGLE] = 1'h1;
      ist_evt[`SMRF_IST_RISE]   = new_flag;
      ist_evt[`SMRF_IST_FALL]   = ~new_flag;
    end

    // Service-routine entry drops the toggle request without a write
    ist_clr[`SMRF_IST_TOGGLE] = avd_irq_ack;
    if (ist_wr) begin
      ist_clr = ist_clr | reg_wdata[`SMRF_IST_W-1:0];
    end
    nxt_st.istat = (st_ff.istat & ~ist_clr) | ist_evt;

    // Control/status register write
    if (csr_wr) begin
      nxt_st.src_sel = reg_wdata[`SMRF_CSR_SRC_SEL];
      nxt_st.irq_en  = reg_wdata[`SMRF_CSR_IRQ_EN];
      // Reset-source flags are write-zero-to-clear; a one is ignored
      if (!reg_wdata[`SMRF_CSR_LVD_RF]) begin
        nxt_st.lvd_rf = 1'h0;
      end
      if (!reg_wdata[`SMRF_CSR_WDG_RF]) begin
        nxt_st.wdg_rf = 1'h0;
      end
    end

    // Mask register write
    if (msk_wr) begin
      nxt_st.imask = reg_wdata[`SMRF_IST_W-1:0];
    end

    // Level interrupt from the next status, so it tracks in the same edge
    nxt_st.irq = |(nxt_st.istat & nxt_st.imask);

    // Read answer stands only in the cycle after the strobe
    nxt_st.rdata = `SMRF_RDATA_IDLE;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_W'(`SMRF_ADDR_CSR): begin
          nxt_st.rdata = {st_ff.src_sel, st_ff.irq_en,
                          st_ff.avd_flag, st_ff.lvd_rf,
                          3'h0, st_ff.wdg_rf};
        end
        ADDR_W'(`SMRF_ADDR_ISTAT): begin
          nxt_st.rdata = {5'h00, st_ff.istat};
        end
        ADDR_W'(`SMRF_ADDR_IMASK): begin
          nxt_st.rdata = {5'h00, st_ff.imask};
        end
        default: begin
          nxt_st.rdata = `SMRF_RDATA_IDLE;
        end
      endcase
    end

    // System reset: control cleared, reset-source flags recorded.
    // Flags are not simply cleared here, since they must outlive the
    // reset that they describe.
    if (!resetn) begin
      nxt_st.src_sel  = 1'(`SMRF_CSR_RESET >> `SMRF_CSR_SRC_SEL);
      nxt_st.irq_en   = 1'h0;
      nxt_st.avd_flag = new_flag;
      nxt_st.istat    = `SMRF_IST_RESET;
      nxt_st.imask    = `SMRF_IMASK_RESET;
      nxt_st.irq      = 1'h0;
      nxt_st.rdata    = `SMRF_RDATA_IDLE;
      // Low-voltage flag kept across pin and watchdog resets; undefined
      // in use while the option is off, so no special case is made
      if (rst_src_lvd) begin
        nxt_st.lvd_rf = 1'h1;
      end else if (rst_src_por) begin
        nxt_st.lvd_rf = 1'h0;
      end else begin
        nxt_st.lvd_rf = st_ff.lvd_rf;
      end
      // Low-voltage reset overrides and clears the watchdog flag
      nxt_st.wdg_rf = rst_src_wdg & ~rst_src_lvd;
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  // Single flop bank; reset is handled in the next-state logic
  always_ff @(posedge ref_clk) begin
    st_ff <= nxt_st;
  end

  // Outputs straight from flops
  assign reg_rdata                 = st_ff.rdata;
  assign aux_detect_threshold_flag = st_ff.avd_flag;
  assign irq                       = st_ff.irq;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking smrf_cb @(posedge ref_clk);
  endclocking

  default disable iff (!resetn);

  // Select bit takes the written value
  src_sel_a: assert property (
    csr_wr |=> st_ff.src_sel == $past(reg_wdata[`SMRF_CSR_SRC_SEL])
  ) else $error("source select not written");

  // Flag held low while the detector option is off
  avd_gate_a: assert property (
    !lvd_option_en |=> !st_ff.avd_flag
  ) else $error("flag set with detector disabled");

  // Enabled flag change makes a pending toggle request
  pend_set_a: assert property (
    (flag_chg && st_ff.irq_en)
      |=> st_ff.istat[`SMRF_IST_TOGGLE]
  ) else $error("flag change lost");

  // Rising change records its direction
  rise_set_a: assert property (
    (flag_chg && st_ff.irq_en && new_flag)
      |=> st_ff.istat[`SMRF_IST_RISE]
  ) else $error("rising change lost");

  // Falling change records its direction
  fall_set_a: assert property (
    (flag_chg && st_ff.irq_en && !new_flag)
      |=> st_ff.istat[`SMRF_IST_FALL]
  ) else $error("falling change lost");

  // No request appears without an enabled flag change
  pend_cause_a: assert property (
    $rose(st_ff.istat[`SMRF_IST_TOGGLE])
      |-> $past(st_ff.irq_en) && $past(flag_chg)
  ) else $error("spurious pending request");

  // Service-routine entry clears the request unless a new change lands
  ack_clr_a: assert property (
    (avd_irq_ack && !(flag_chg && st_ff.irq_en))
      |=> !st_ff.istat[`SMRF_IST_TOGGLE]
  ) else $error("pending not cleared by acknowledge");

  // Flag changes only toward the gated, synchronised comparator
  flag_src_a: assert property (
    !$stable(st_ff.avd_flag)
      |-> st_ff.avd_flag == $past(lvd_option_en & sel_cmp)
  ) else $error("flag moved without comparator cause");

  // Outside reset, the low-voltage flag falls only on a write of zero
  lvd_keep_a: assert property (
    $fell(st_ff.lvd_rf)
      |-> $past(csr_wr) && !$past(reg_wdata[`SMRF_CSR_LVD_RF])
  ) else $error("low-voltage flag lost");

  // Watchdog flag falls only on a write of zero or at reset
  wdg_clr_a: assert property (
    $fell(st_ff.wdg_rf)
      |-> ($past(csr_wr) && !$past(reg_wdata[`SMRF_CSR_WDG_RF]))
          || !$past(resetn)
  ) else $error("watchdog flag lost");

  // Reserved bits always read zero, answer one cycle after the strobe
  rsv_zero_a: assert property (
    (reg_rd && reg_addr == ADDR_W'(`SMRF_ADDR_CSR))
      |=> reg_rdata[`SMRF_CSR_RSV_HI:`SMRF_CSR_RSV_LO] == 3'h0
          && reg_rdata[`SMRF_CSR_FLAG] == $past(st_ff.avd_flag)
  ) else $error("control read wrong");

  // Read port idles at zero outside the answer cycle
  rd_idle_a: assert property (
    !reg_rd |=> reg_rdata == `SMRF_RDATA_IDLE
  ) else $error("read data outside answer cycle");

  // Low-voltage reset records itself and clears the watchdog flag;
  // these must run while reset is low, so the default disable is overridden
  lvd_rst_a: assert property (
    disable iff (1'b0)
    (!resetn && rst_src_lvd) |=> st_ff.lvd_rf && !st_ff.wdg_rf
  ) else $error("low-voltage reset not recorded");

  // Pin and watchdog resets keep the low-voltage record
  lvd_hold_a: assert property (
    disable iff (1'b0)
    (!resetn && !rst_src_lvd && !rst_src_por)
      |=> st_ff.lvd_rf == $past(st_ff.lvd_rf)
  ) else $error("low-voltage flag lost in reset");

  // Control bits and read port cleared by reset
  ctrl_rst_a: assert property (
    disable iff (1'b0)
    !resetn |=> !st_ff.src_sel && !st_ff.irq_en && reg_rdata == `SMRF_RDATA_IDLE
  ) else $error("control bits not cleared by reset");

  // Interrupt line follows status and mask
  irq_out_a: assert property (
    irq == |(st_ff.istat & st_ff.imask)
  ) else $error("interrupt line mismatch");

  // Main scenarios
  cov_toggle_c: cover property (
    st_ff.irq_en && flag_chg ##1 irq ##[1:20] avd_irq_ack
  );

  cov_evd_c: cover property (
    st_ff.src_sel && $rose(st_ff.avd_flag)
  );

  cov_lvd_rst_c: cover property (
    disable iff (1'b0)
    !resetn && rst_src_lvd ##1 resetn
  );

  cov_clear_c: cover property (
    st_ff.lvd_rf ##1 (csr_wr && !reg_wdata[`SMRF_CSR_LVD_RF]) ##1 !st_ff.lvd_rf
  );

endmodule

`default_nettype wire

// File: rtl/smrf_map.svh
// Register offsets, field positions and reset values of the supply monitor block
`ifndef SMRF_MAP_SVH
`define SMRF_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SMRF_ADDR_CSR   8'h00
`define SMRF_ADDR_ISTAT 8'h01
`define SMRF_ADDR_IMASK 8'h02

// ----------------------------------------------------------------------------
// Control/status register fields
// ----------------------------------------------------------------------------
`define SMRF_CSR_SRC_SEL 7
`define SMRF_CSR_IRQ_EN  6
`define SMRF_CSR_FLAG    5
`define SMRF_CSR_LVD_RF  4
`define SMRF_CSR_RSV_HI  3
`define SMRF_CSR_RSV_LO  1
`define SMRF_CSR_WDG_RF  0

// ----------------------------------------------------------------------------
// Interrupt status and mask fields
// ----------------------------------------------------------------------------
`define SMRF_IST_TOGGLE 0
`define SMRF_IST_RISE   1
`define SMRF_IST_FALL   2
`define SMRF_IST_W      3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SMRF_CSR_RESET   8'h00
`define SMRF_IST_RESET   3'h0
`define SMRF_IMASK_RESET 3'h0
`define SMRF_RDATA_IDLE  8'h00

`endif

// File: rtl/smrf_pkg.sv
// Types shared by the supply monitor block
package smrf_pkg;

  // --------------------------------------------------------------------------
  // Complete state of the top module
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       src_sel;
    logic       irq_en;
    logic       avd_flag;
    logic       lvd_rf;
    logic       wdg_rf;
    logic [2:0] istat;
    logic [2:0] imask;
    logic       irq;
    logic [7:0] rdata;
  } smrf_state_t;

endpackage

// File: rtl/smrf_sync.sv
// Two-stage synchroniser for comparator levels
`timescale 1ns/1ps
`default_nettype none

module smrf_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s1;
  } smrf_sync_t;

  smrf_sync_t st_ff;
  smrf_sync_t nxt_st;

  // First stage feeds only the second stage
  always_comb begin
    nxt_st.s1 = async_in;
    nxt_st.s2 = st_ff.s1;
    if (!resetn) begin
      nxt_st = '0;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    st_ff <= nxt_st;
  end

  assign sync_out = st_ff.s2;

endmodule

`default_nettype wire

// File: verif/tb_supply_monitor_reset_flags.sv
// Self-checking bench for the supply monitor control, interrupt and reset-source flags
`timescale 1ns/1ps
`default_nettype none

`include "smrf_map.svh"

module tb_supply_monitor_reset_flags;
  logic       ref_clk, resetn, reg_wr, reg_rd, lvd_option_en, avd_cmp_vdd, avd_cmp_evd;
  logic       rst_src_por, rst_src_lvd, rst_src_wdg, avd_irq_ack;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       aux_detect_threshold_flag, irq;
  int         miscompares, total_checks, cycles;

  smrf_top uut (
    .ref_clk                   (ref_clk),
    .resetn                    (resetn),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_wr                    (reg_wr),
    .reg_rd                    (reg_rd),
    .reg_rdata                 (reg_rdata),
    .lvd_option_en             (lvd_option_en),
    .avd_cmp_vdd               (avd_cmp_vdd),
    .avd_cmp_evd               (avd_cmp_evd),
    .rst_src_por               (rst_src_por),
    .rst_src_lvd               (rst_src_lvd),
    .rst_src_wdg               (rst_src_wdg),
    .avd_irq_ack               (avd_irq_ack),
    .aux_detect_threshold_flag (aux_detect_threshold_flag),
    .irq                       (irq)
  );

  // ---------------------------------------------------------------------------
  // Clock, time-zero values, hang guard
  // ---------------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0; resetn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    lvd_option_en = 1'b1; avd_cmp_vdd = 1'b0; avd_cmp_evd = 1'b0; avd_irq_ack = 1'b0;
    rst_src_por = 1'b1; rst_src_lvd = 1'b0; rst_src_wdg = 1'b0;
    miscompares = 0; total_checks = 0; cycles = 0;
  end
  always #12.5 ref_clk = ~ref_clk;

  // Whole run is about 150 cycles; the ceiling leaves a wide margin
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      stop_test();
    end
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic stop_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(name, reg_rdata, exp);
    // Back on a rising edge so later stimulus lands on the clock
    @(posedge ref_clk);
  endtask

  // Causes stay put across the last low edge, then drop one edge later
  task automatic do_reset(input logic p, input logic l, input logic w);
    @(posedge ref_clk);
    resetn <= 1'b0; rst_src_por <= p; rst_src_lvd <= l; rst_src_wdg <= w;
    wait_clk(8);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rst_src_por <= 1'b0; rst_src_lvd <= 1'b0; rst_src_wdg <= 1'b0;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic s_reset_values();
    do_reset(1'b1, 1'b0, 1'b0);
    rchk("csr", `SMRF_ADDR_CSR, 8'h00);
    rchk("istat", `SMRF_ADDR_ISTAT, 8'h00);
    rchk("imask", `SMRF_ADDR_IMASK, 8'h00);
    rchk("unmapped", 8'h7F, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
  endtask

  // Option gating, source choice and read-only flag, all with interrupts off
  task automatic s_select();
    lvd_option_en <= 1'b0; avd_cmp_vdd <= 1'b1;
    wait_clk(4);
    chk("flag_gated", {7'h00, aux_detect_threshold_flag}, 8'h00);
    lvd_option_en <= 1'b1;
    wait_clk(4);
    rchk("csr_vdd", `SMRF_ADDR_CSR, 8'h20);
    chk("flag_out", {7'h00, aux_detect_threshold_flag}, 8'h01);
    avd_cmp_vdd <= 1'b0; avd_cmp_evd <= 1'b1;
    wr(`SMRF_ADDR_CSR, 8'h80);
    wait_clk(4);
    rchk("csr_evd", `SMRF_ADDR_CSR, 8'hA0);
    wr(`SMRF_ADDR_CSR, 8'h20);
    wait_clk(4);
    rchk("csr_ro", `SMRF_ADDR_CSR, 8'h00);
    rchk("istat_off", `SMRF_ADDR_ISTAT, 8'h00);
    avd_cmp_evd <= 1'b0;
  endtask

  task automatic s_irq();
    wr(`SMRF_ADDR_IMASK, 8'h07);
    wr(`SMRF_ADDR_CSR, 8'h40);
    avd_cmp_vdd <= 1'b1;
    wait_clk(4);
    rchk("istat_rise", `SMRF_ADDR_ISTAT, 8'h03);
    chk("irq_rise", {7'h00, irq}, 8'h01);
    @(posedge ref_clk);
    avd_irq_ack <= 1'b1;
    @(posedge ref_clk);
    avd_irq_ack <= 1'b0;
    rchk("istat_ack", `SMRF_ADDR_ISTAT, 8'h02);
    wr(`SMRF_ADDR_ISTAT, 8'h02);
    wait_clk(1);
    chk("irq_clr", {7'h00, irq}, 8'h00);
    avd_cmp_vdd <= 1'b0;
    wait_clk(4);
    rchk("istat_fall", `SMRF_ADDR_ISTAT, 8'h05);
    wr(`SMRF_ADDR_IMASK, 8'h00);
    wait_clk(1);
    chk("irq_masked", {7'h00, irq}, 8'h00);
    wr(`SMRF_ADDR_ISTAT, 8'h07);
    wr(`SMRF_ADDR_CSR, 8'h00);
  endtask

  // Reset-source flags across a chain of resets; reserved bits always written zero
  task automatic s_reset_flags();
    do_reset(1'b0, 1'b0, 1'b1);
    rchk("wdg", `SMRF_ADDR_CSR, 8'h01);
    wr(`SMRF_ADDR_CSR, 8'h00);
    rchk("wdg_clr", `SMRF_ADDR_CSR, 8'h00);
    do_reset(1'b0, 1'b1, 1'b1);
    rchk("lvd", `SMRF_ADDR_CSR, 8'h10);
    wr(`SMRF_ADDR_CSR, 8'h11);
    rchk("lvd_w1", `SMRF_ADDR_CSR, 8'h10);
    do_reset(1'b0, 1'b0, 1'b1);
    rchk("lvd_wdg", `SMRF_ADDR_CSR, 8'h11);
    do_reset(1'b0, 1'b0, 1'b0);
    rchk("lvd_ext", `SMRF_ADDR_CSR, 8'h10);
    wr(`SMRF_ADDR_CSR, 8'h00);
    rchk("lvd_clr", `SMRF_ADDR_CSR, 8'h00);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    s_reset_values();
    s_select();
    s_irq();
    s_reset_flags();
    stop_test();
  end
endmodule

`default_nettype wire
